// *** hw/seq_ram.sv ***
// Sequential-access dual-port RAM: host port on AHB-Lite, clocked sequential port.
`timescale 1ns/1ps
`default_nettype none
`include "seq_ram_consts.svh"
module seq_ram (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sequential port pins.
  input wire logic seq_reset_n,
  input wire logic seq_chip_enable_n,
  input wire logic seq_read_write,
  input wire logic seq_pointer_load,
  input wire logic [1:0] buffer_restart,
  input wire logic seq_oe_n,
  input wire logic [`SEQ_DATA_W-1:0] seq_dq_in,
  output logic [`SEQ_DATA_W-1:0] seq_dq_out,
  output logic seq_dq_oe,
  output logic [1:0] seq_end_flag
);
  import seq_ram_pkg::*;

  // Current and next state.
  state_t r;
  state_t n;

  // Synchronised sequential inputs, taken from the second stage only.
  logic s_rst_n;
  logic s_ce_n;
  logic s_read;
  logic s_load;
  logic [1:0] s_restart;
  logic [`SEQ_DATA_W-1:0] s_din;
  assign {s_rst_n, s_ce_n, s_read, s_load, s_restart, s_din} = r.s2;

  // An access happens on this edge.
  logic access;
  assign access = s_rst_n && r.seq_en && !s_load && (s_restart == 2'b00) && !s_ce_n
                  && !r.stopped;
  // Pointer sits on the active buffer's end address; ranges are free to overlap.
  logic at_end;
  assign at_end = (r.ptr == r.fin[r.buf_sel]);

  // Host address decode helpers.
  logic regsel;
  assign regsel = r.haddr_q[`REG_SELECT_BIT];
  logic [11:0] roff;
  assign roff = r.haddr_q[11:0];
  logic [`SEQ_ADDR_W-1:0] aidx;
  assign aidx = r.haddr_q[`SEQ_ADDR_W+1:2];
  // Host write in this cycle that wipes all sequential control state not set by a sequential load, restart or access in the same cycle.
  // The pointer may legally jump to zero then, even while the port is stopped.
  logic host_clr;
  assign host_clr = (r.phase == PH_DATA) && r.hwrite_q && regsel
                    && (roff == `REG_FLAG_CTRL) && hwdata[`CLR_REGS_BIT];

  // Next-state logic for bus, registers, pointer and array.
  always_comb begin
    n = r;
    // Two-stage input synchroniser.
    n.s1 = {seq_reset_n, seq_chip_enable_n, seq_read_write, seq_pointer_load,
            buffer_restart, seq_dq_in};
    n.s2 = r.s1;
    // Host bus: accept, one wait cycle, then complete.
    case (r.phase)
      PH_IDLE: begin
        if (hsel && htrans[1] && hready) begin
          n.phase = PH_DATA;
          n.hready = 1'b0;
          n.haddr_q = haddr[12:0];
          n.hwrite_q = hwrite;
          // Byte lanes of the 16-bit array word.
          n.be_q[0] = (hsize != 3'h0) || (haddr[1:0] == 2'h0);
          n.be_q[1] = (hsize >= 3'h2) || (haddr[1:0] == 2'h1) || (hsize == 3'h1
                      && haddr[1:0] == 2'h0);
        end
      end
      default: begin
        n.phase = PH_IDLE;
        n.hready = 1'b1;
        n.hrdata = 32'h0000_0000;
        if (regsel) begin
          // Control register space.
          if (r.hwrite_q) begin
            if (roff == `REG_BUF0_BEGIN) begin
              n.beg[0] = hwdata[`SEQ_ADDR_W-1:0];
            end else if (roff == `REG_BUF0_END) begin
              n.fin[0] = hwdata[`SEQ_ADDR_W-1:0];
            end else if (roff == `REG_BUF1_BEGIN) begin
              n.beg[1] = hwdata[`SEQ_ADDR_W-1:0];
            end else if (roff == `REG_BUF1_END) begin
              n.fin[1] = hwdata[`SEQ_ADDR_W-1:0];
            end else if (roff == `REG_END_ACTION) begin
              n.act[0] = hwdata[`ACT0_LSB+:3];
              n.act[1] = hwdata[`ACT1_LSB+:3];
              n.seq_en = hwdata[`SEQ_ENABLE_BIT];
            end else if (roff == `REG_FLAG_CTRL) begin
              if (hwdata[`CLR_FLAGS_BIT]) begin
                n.flag = 2'b00;
              end
              if (hwdata[`CLR_REGS_BIT]) begin
                // Clear all sequential control state.
                n.beg = {2{`BUF_BEGIN_RESET}};
                n.fin = {2{`BUF_END_RESET}};
                n.act = '0;
                n.seq_en = 1'b0;
                n.ptr = '0;
                n.buf_sel = 1'b0;
                n.stopped = 1'b0;
                n.flag = 2'b00;
              end
            end
          end else begin
            if (roff == `REG_BUF0_BEGIN) begin
              n.hrdata[`SEQ_ADDR_W-1:0] = r.beg[0];
            end else if (roff == `REG_BUF0_END) begin
              n.hrdata[`SEQ_ADDR_W-1:0] = r.fin[0];
            end else if (roff == `REG_BUF1_BEGIN) begin
              n.hrdata[`SEQ_ADDR_W-1:0] = r.beg[1];
            end else if (roff == `REG_BUF1_END) begin
              n.hrdata[`SEQ_ADDR_W-1:0] = r.fin[1];
            end else if (roff == `REG_END_ACTION) begin
              n.hrdata[`ACT0_LSB+:3] = r.act[0];
              n.hrdata[`ACT1_LSB+:3] = r.act[1];
              n.hrdata[`SEQ_ENABLE_BIT] = r.seq_en;
            end else if (roff == `REG_FLAG_CTRL) begin
              n.hrdata[3:0] = {r.buf_sel, r.stopped, r.flag};
            end else if (roff == `REG_POINTER) begin
              n.hrdata[`SEQ_ADDR_W-1:0] = r.ptr;
            end
          end
        end else begin
          // Array space, byte-selectable.
          if (r.hwrite_q) begin
            if (r.be_q[0]) begin
              n.mem[aidx][7:0] = hwdata[7:0];
            end
            if (r.be_q[1]) begin
              n.mem[aidx][15:8] = hwdata[15:8];
            end
          end else begin
            n.hrdata[`SEQ_DATA_W-1:0] = r.mem[aidx];
          end
        end
      end
    endcase
    // Sequential port; placed last so its flag sets beat a host clear.
    if (!s_rst_n) begin
      n.beg = {2{`BUF_BEGIN_RESET}};
      n.fin = {2{`BUF_END_RESET}};
      n.seq_en = 1'b0;
      n.ptr = '0;
      n.buf_sel = 1'b0;
      n.stopped = 1'b0;
      n.dq_drive = 1'b0;
    end else if (r.seq_en) begin
      if (s_load) begin
        // Load wins over restart.
        n.ptr = s_din[`SEQ_ADDR_W-1:0];
        n.stopped = 1'b0;
      end else if (s_restart != 2'b00) begin
        // Buffer 0 restart wins if both are asserted.
        n.buf_sel = !s_restart[0];
        n.ptr = r.beg[!s_restart[0]];
        n.stopped = 1'b0;
      end else if (access) begin
        // One 16-bit word per enabled edge.
        if (s_read) begin
          n.dq_out = r.mem[r.ptr];
          n.dq_drive = 1'b1;
        end else begin
          n.mem[r.ptr] = s_din;
          n.dq_drive = 1'b0;
        end
        if (at_end) begin
          case (r.act[r.buf_sel])
            ACT_WRAP: n.ptr = r.beg[r.buf_sel];
            ACT_JUMP: begin
              n.ptr = r.beg[!r.buf_sel];
              n.buf_sel = !r.buf_sel;
            end
            ACT_STOP: n.stopped = 1'b1;
            ACT_FLAG: begin
              n.flag[r.buf_sel] = 1'b1;
              n.ptr = r.beg[r.buf_sel];
            end
            default: n.ptr = r.ptr + 1'b1;
          endcase
        end else begin
          n.ptr = r.ptr + 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.fin <= {2{`BUF_END_RESET}};
      r.hready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs from flip-flops, hresp tied low; the data enable obeys the pin asynchronously.
  assign hreadyout = r.hready;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign seq_dq_out = r.dq_out;
  assign seq_end_flag = r.flag;
  assign seq_dq_oe = r.dq_drive && !seq_oe_n;

  // Checks.
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A register write lands in the register, not the array.
  chk_regsel_write: assert property (
    (r.phase == PH_DATA && r.hwrite_q && regsel && roff == `REG_BUF0_BEGIN && s_rst_n
     && !(hwdata[`CLR_REGS_BIT] && roff == `REG_FLAG_CTRL))
    |=> r.beg[0] == $past(hwdata[`SEQ_ADDR_W-1:0]))
    else $error("buffer begin not written");
  // Bus answers after exactly one wait cycle.
  chk_bus_answer: assert property (
    (r.phase == PH_IDLE && hsel && htrans[1] && hready) |=> !hreadyout ##1 hreadyout)
    else $error("bus answer timing wrong");
  // Wrap returns to the buffer's own beginning.
  chk_wrap_begin: assert property (
    (access && at_end && r.act[r.buf_sel] == ACT_WRAP) |=> r.ptr == $past(r.beg[r.buf_sel]))
    else $error("wrap did not return to begin");
  // A stopped port holds its pointer.
  chk_stop_holds: assert property (
    (r.stopped && s_rst_n && !s_load && s_restart == 2'b00 && !host_clr) |=> $stable(r.ptr))
    else $error("stopped pointer moved");
  // Flag action raises the flag.
  chk_flag_set: assert property (
    (access && at_end && r.act[r.buf_sel] == ACT_FLAG) |=> r.flag[$past(r.buf_sel)])
    else $error("end flag not raised");
  // Restart of buffer 0 loads its beginning.
  chk_restart_ptr: assert property (
    (s_rst_n && r.seq_en && !s_load && s_restart[0]) |=> r.ptr == $past(r.beg[0]) && !r.buf_sel)
    else $error("restart pointer wrong");
  // Load beats restart.
  chk_load_prio: assert property (
    (s_rst_n && r.seq_en && s_load) |=> r.ptr == $past(s_din[`SEQ_ADDR_W-1:0]))
    else $error("pointer load failed");
  // Plain access steps by one.
  chk_ptr_step: assert property (
    (access && !at_end) |=> r.ptr == $past(r.ptr) + 8'h01)
    else $error("pointer did not step");
  // Sequential reset restores buffer bounds and pointer and disables; end actions and flags keep their values.
  chk_seq_reset: assert property (
    !s_rst_n |=> !r.seq_en && r.fin[1] == `BUF_END_RESET && r.ptr == 8'h00)
    else $error("sequential reset incomplete");
  cov_jump: cover property (access && at_end && r.act[r.buf_sel] == ACT_JUMP);
  cov_read_drive: cover property (access && s_read ##1 seq_dq_oe);
  cov_reg_read: cover property (r.phase == PH_DATA && !r.hwrite_q && regsel);
  // A register-space write leaves the array word that shares its index alone.
  // Sequential accesses in the same cycle are left out, as they may write that word.
  chk_regsel_array: assert property (
    (r.phase == PH_DATA && r.hwrite_q && regsel && !access)
    |=> r.mem[$past(aidx)] == $past(r.mem[aidx]))
    else $error("register write reached the array");
  // Continuing past the end, and a restart of the second buffer.
  cov_cont: cover property (access && at_end && r.act[r.buf_sel] == ACT_CONT);
  cov_restart1: cover property (s_rst_n && r.seq_en && !s_load && s_restart == 2'b10);
endmodule
`default_nettype wire

// *** hw/seq_ram_consts.svh ***
// Constants for the sequential-access dual-port RAM.
`ifndef SEQ_RAM_CONSTS_SVH
`define SEQ_RAM_CONSTS_SVH
`define SEQ_ADDR_W 8
`define SEQ_DEPTH 256
`define SEQ_DATA_W 16
`define SYNC_W 22
`define REG_SELECT_BIT 12
`define REG_BUF0_BEGIN 12'h000
`define REG_BUF0_END 12'h004
`define REG_BUF1_BEGIN 12'h008
`define REG_BUF1_END 12'h00c
`define REG_END_ACTION 12'h010
`define REG_FLAG_CTRL 12'h014
`define REG_POINTER 12'h018
`define ACT0_LSB 0
`define ACT1_LSB 4
`define SEQ_ENABLE_BIT 8
`define CLR_FLAGS_BIT 0
`define CLR_REGS_BIT 1
`define BUF_BEGIN_RESET 8'h00
`define BUF_END_RESET 8'hff
`endif

// *** hw/seq_ram_pkg.sv ***
// Types shared by the sequential-access dual-port RAM.
`include "seq_ram_consts.svh"
package seq_ram_pkg;
  // End-of-buffer actions, encoded 0 to 4 in declaration order.
  typedef enum logic [2:0] {ACT_WRAP, ACT_JUMP, ACT_STOP, ACT_FLAG, ACT_CONT} end_action_t;
  // Host bus phase.
  typedef enum logic {PH_IDLE, PH_DATA} bus_phase_t;
  // All state of the RAM.
  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
    logic [1:0][`SEQ_ADDR_W-1:0] beg;
    logic [1:0][`SEQ_ADDR_W-1:0] fin;
    logic [1:0][2:0] act;
    logic seq_en;
    logic [`SEQ_ADDR_W-1:0] ptr;
    logic buf_sel;
    logic stopped;
    logic [1:0] flag;
    logic [`SEQ_DATA_W-1:0] dq_out;
    logic dq_drive;
    bus_phase_t phase;
    logic [12:0] haddr_q;
    logic hwrite_q;
    logic [1:0] be_q;
    logic hready;
    logic [31:0] hrdata;
    logic [`SEQ_DEPTH-1:0][`SEQ_DATA_W-1:0] mem;
  } state_t;
endpackage

// *** test/seq_dsp_model.sv ***
// Model of the streaming controller that drives the sequential port.
`timescale 1ns/1ps
`default_nettype none
module seq_dsp_model (
  // Clock shared with the RAM.
  input wire logic hclk,
  // Sequential pins toward the RAM.
  output logic seq_chip_enable_n,
  output logic seq_read_write,
  output logic seq_pointer_load,
  output logic [1:0] buffer_restart,
  output logic seq_oe_n,
  output logic [15:0] seq_dq_in
);
  // Pins idle at time zero, with an arbitrary pattern on the data bus.
  initial begin
    seq_chip_enable_n = 1'b1;
    seq_read_write = 1'b1;
    seq_pointer_load = 1'b0;
    buffer_restart = 2'b00;
    seq_oe_n = 1'b0;
    seq_dq_in = 16'h5a5a;
  end
  // One request stands one clock; data stands four so it crosses the input stages.
  task automatic op(input logic ce, input logic rw, input logic ld, input logic [1:0] rs,
                    input logic [15:0] d, input int gap);
    @(posedge hclk);
    seq_chip_enable_n <= !ce;
    seq_read_write <= rw;
    seq_pointer_load <= ld;
    buffer_restart <= rs;
    seq_dq_in <= d;
    @(posedge hclk);
    seq_chip_enable_n <= 1'b1;
    seq_pointer_load <= 1'b0;
    buffer_restart <= 2'b00;
    repeat (3) @(posedge hclk);
    // A released bus shows the inverse of its last value, not a held copy.
    seq_dq_in <= ~d;
    repeat (gap) @(posedge hclk);
  endtask
  // Drives the asynchronous output enable; call it just after a clock edge.
  task automatic set_oe(input logic en_n);
    seq_oe_n <= en_n;
  endtask
endmodule
`default_nettype wire

// *** test/seq_ram_test.sv ***
// Self-checking bench for the sequential-access dual-port RAM.
`timescale 1ns/1ps
`default_nettype none
`include "seq_ram_consts.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module seq_ram_test;
  // Host bus and sequential reset, driven by this bench.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic seq_reset_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  // Design outputs and controller pins.
  logic hreadyout, hresp, seq_dq_oe, seq_chip_enable_n, seq_read_write;
  logic seq_pointer_load, seq_oe_n;
  logic [1:0] buffer_restart, seq_end_flag;
  logic [31:0] hrdata, bexp;
  logic [15:0] seq_dq_out, seq_dq_in, sexp;
  // Expected-result notes, counters and the array image.
  logic [31:0] bus_q[$];
  logic [15:0] seq_q[$];
  logic [15:0] w[0:9];
  logic rd_pend = 1'b0;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 31;
  int ord_a[4] = '{2, 3, 4, 2};
  int ord_b[5] = '{3, 4, 6, 7, 6};
  localparam logic [31:0] RB = 32'h0000_1000;
  // Clock of 5 ns period.
  always #2.5 hclk = ~hclk;
  seq_ram i_seq_ram (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .seq_reset_n(seq_reset_n),
    .seq_chip_enable_n(seq_chip_enable_n), .seq_read_write(seq_read_write),
    .seq_pointer_load(seq_pointer_load), .buffer_restart(buffer_restart),
    .seq_oe_n(seq_oe_n), .seq_dq_in(seq_dq_in), .seq_dq_out(seq_dq_out),
    .seq_dq_oe(seq_dq_oe), .seq_end_flag(seq_end_flag));
  seq_dsp_model i_seq_dsp_model (.hclk(hclk), .seq_chip_enable_n(seq_chip_enable_n),
    .seq_read_write(seq_read_write), .seq_pointer_load(seq_pointer_load),
    .buffer_restart(buffer_restart), .seq_oe_n(seq_oe_n), .seq_dq_in(seq_dq_in));
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One single transfer: address phase held until taken, then the data phase.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [2:0] sz);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_pend <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_pend <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus_q.push_back(e);
    ahb(1'b0, a, 32'h0000_0000, 3'h2);
  endtask
  task automatic wreg(input logic [11:0] off, input logic [31:0] d);
    ahb(1'b1, RB | 32'(off), d, 3'h2);
  endtask
  task automatic rreg(input logic [11:0] off, input logic [31:0] e);
    rd(RB | 32'(off), e);
  endtask
  // One sequential read; a note is kept only when an access should occur.
  task automatic sr(input int i, input logic hit);
    if (hit) seq_q.push_back(w[i]);
    i_seq_dsp_model.op(1'b1, 1'b1, 1'b0, 2'b00, 16'($random(seed)), 1);
  endtask
  // Completed host reads meet the oldest note; the timeout also lives here.
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      bexp = bus_q.pop_front();
      `CHK(hrdata, bexp)
      `CHK(hresp, 1'b0)
    end
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // Every new sequential word must match a note; a surplus word never does.
  always @(seq_dq_out) begin
    if (hresetn === 1'b1) begin
      sexp = (seq_q.size() > 0) ? seq_q.pop_front() : 16'hxxxx;
      `CHK(seq_dq_out, sexp)
    end
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    seq_reset_n <= 1'b1;
    rreg(`REG_BUF0_END, 32'h0000_00ff);
    rreg(`REG_POINTER, 32'h0000_0000);
    rreg(12'h01c, 32'h0000_0000);
    $display("test reset_values done");
    w[0] = 16'h0000;
    for (int i = 1; i < 10; i++) begin
      w[i] = {8'($random(seed)), 8'(i)};
      ahb(1'b1, 32'(4 * i), {16'h0000, w[i]}, 3'h2);
    end
    w[9][15:8] = 8'ha5;
    ahb(1'b1, 32'h0000_0025, 32'h0000_a500, 3'h0);
    rd(32'h0000_0024, {16'h0000, w[9]});
    $display("test array_fill done");
    wreg(`REG_BUF0_BEGIN, 32'h0000_0002);
    wreg(`REG_BUF0_END, 32'h0000_0004);
    wreg(`REG_BUF1_BEGIN, 32'h0000_0006);
    wreg(`REG_BUF1_END, 32'h0000_0007);
    wreg(`REG_END_ACTION, 32'h0000_0130);
    rd(32'h0000_0000, 32'h0000_0000);
    i_seq_dsp_model.op(1'b0, 1'b1, 1'b0, 2'b01, 16'h0000, 2);
    foreach (ord_a[k]) sr(ord_a[k], 1'b1);
    rreg(`REG_POINTER, 32'h0000_0003);
    wreg(`REG_END_ACTION, 32'h0000_0131);
    foreach (ord_b[k]) sr(ord_b[k], 1'b1);
    rreg(`REG_FLAG_CTRL, 32'h0000_000a);
    `CHK(seq_end_flag, 2'b10)
    wreg(`REG_FLAG_CTRL, 32'h0000_0001);
    rreg(`REG_FLAG_CTRL, 32'h0000_0008);
    `CHK(seq_end_flag, 2'b00)
    $display("test wrap_jump_flag done");
    wreg(`REG_END_ACTION, 32'h0000_0121);
    sr(7, 1'b1);
    sr(0, 1'b0);
    rreg(`REG_FLAG_CTRL, 32'h0000_000c);
    i_seq_dsp_model.op(1'b0, 1'b1, 1'b1, 2'b01, 16'h0001, 2);
    sr(1, 1'b1);
    rreg(`REG_POINTER, 32'h0000_0002);
    $display("test stop_load done");
    `CHK(seq_dq_oe, 1'b1)
    @(posedge hclk);
    i_seq_dsp_model.set_oe(1'b1);
    #1 `CHK(seq_dq_oe, 1'b0)
    @(posedge hclk);
    i_seq_dsp_model.set_oe(1'b0);
    i_seq_dsp_model.op(1'b1, 1'b0, 1'b0, 2'b00, 16'hbeef, 2);
    rd(32'h0000_0008, 32'h0000_beef);
    w[2] = 16'hbeef;
    `CHK(seq_dq_oe, 1'b0)
    $display("test write_oe done");
    @(posedge hclk);
    seq_reset_n <= 1'b0;
    repeat (4) @(posedge hclk);
    seq_reset_n <= 1'b1;
    repeat (4) @(posedge hclk);
    rreg(`REG_BUF0_BEGIN, 32'h0000_0000);
    rreg(`REG_END_ACTION, 32'h0000_0021);
    sr(0, 1'b0);
    wreg(`REG_FLAG_CTRL, 32'h0000_0002);
    rreg(`REG_END_ACTION, 32'h0000_0000);
    $display("test seq_reset_clear done");
    wreg(`REG_BUF1_END, 32'h0000_0001);
    wreg(`REG_END_ACTION, 32'h0000_0140);
    i_seq_dsp_model.op(1'b0, 1'b1, 1'b0, 2'b10, 16'h0000, 2);
    rreg(`REG_FLAG_CTRL, 32'h0000_0008);
    sr(0, 1'b1);
    sr(1, 1'b1);
    sr(2, 1'b1);
    rreg(`REG_POINTER, 32'h0000_0003);
    $display("test continue_restart done");
    repeat (4) @(posedge hclk);
    `CHK(seq_q.size(), 0)
    `CHK(bus_q.size(), 0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
